// >>> hdl/mds_map.vh
/*
  register map, field positions, codes and reset values of the
  multiply-accumulate slice. assumes 32-bit aligned axi4-lite words.
*/
`ifndef MDS_MAP_VH
`define MDS_MAP_VH

// register byte offsets
`define MDS_CTRL_OFS      4'h0
`define MDS_SEL_OFS       4'h4
`define MDS_STAT_OFS      4'h8
`define MDS_ADDR_W        4

// ctrl fields
`define MDS_F_TYPE_LO     0
`define MDS_F_TYPE_HI     1
`define MDS_F_WID_LO      2
`define MDS_F_WID_HI      3
`define MDS_F_IN_EN       4
`define MDS_F_PIPE_EN     5
`define MDS_F_OUT_EN      6
`define MDS_F_DYN         7
`define MDS_F_SIGNED      8
`define MDS_F_SUB         9
`define MDS_F_SHIFT       10
`define MDS_CTRL_MASK     32'h0000_07ff
`define MDS_CTRL_RST      32'h0000_0070

// sel fields: clock, enable, reset choice per stage, 2 bits each
`define MDS_SEL_MASK      32'h0003_ffff
`define MDS_SEL_RST       32'h0000_0000
`define MDS_SEL_CLK       0
`define MDS_SEL_CE        6
`define MDS_SEL_RS        12
`define MDS_STG_IN        0
`define MDS_STG_PIPE      2
`define MDS_STG_OUT       4

// status fields
`define MDS_ST_ERR        0
`define MDS_ST_MAX_LO     1
`define MDS_ST_MAX_HI     4
`define MDS_ST_CNT_LO     16
`define MDS_ST_CNT_HI     31

// element and width codes
`define MDS_T_PLAIN_MULTIPLY_ELEMENT        2'h0
`define MDS_T_MAC         2'h1
`define MDS_T_TWO         2'h2
`define MDS_T_FOUR        2'h3
`define MDS_W_9           2'h0
`define MDS_W_18          2'h1
`define MDS_W_36          2'h2

`define MDS_RESP_OK       2'h0
`define MDS_RESP_ERR      2'h2

`endif

// >>> hdl/mds_slice.v
/*
  multiply-accumulate slice: four product lanes, optional input and
  pipeline stages, output stage optional outside mac mode, each on a chosen clock source, enable
  and reset; configured over axi4-lite. assumes all inputs are
  synchronous to clk and the four clock sources are slow tick levels.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mds_map.vh"

module mds_slice #(
  parameter OP_W  = 36,
  parameter ACC_W = 52
) (
  // system
  input  wire                 clk,
  input  wire                 rstn,
  // axi4-lite slave
  input  wire [3:0]           s_axi_awaddr,
  input  wire                 s_axi_awvalid,
  output reg                  s_axi_awready,
  input  wire [31:0]          s_axi_wdata,
  input  wire [3:0]           s_axi_wstrb,
  input  wire                 s_axi_wvalid,
  output reg                  s_axi_wready,
  output reg  [1:0]           s_axi_bresp,
  output reg                  s_axi_bvalid,
  input  wire                 s_axi_bready,
  input  wire [3:0]           s_axi_araddr,
  input  wire                 s_axi_arvalid,
  output reg                  s_axi_arready,
  output reg  [31:0]          s_axi_rdata,
  output reg  [1:0]           s_axi_rresp,
  output reg                  s_axi_rvalid,
  input  wire                 s_axi_rready,
  // slice clock, enable and reset sources
  input  wire                 slice_clock_source_0,
  input  wire                 slice_clock_source_1,
  input  wire                 slice_clock_source_2,
  input  wire                 slice_clock_source_3,
  input  wire                 slice_enable_source_0,
  input  wire                 slice_enable_source_1,
  input  wire                 slice_enable_source_2,
  input  wire                 slice_enable_source_3,
  input  wire                 slice_reset_source_0,
  input  wire                 slice_reset_source_1,
  input  wire                 slice_reset_source_2,
  input  wire                 slice_reset_source_3,
  // operands, lane i at bits [i*OP_W +: OP_W]
  input  wire [4*OP_W-1:0]    a_in,
  input  wire [4*OP_W-1:0]    b_in,
  input  wire [OP_W-1:0]      a_shift_in,
  input  wire [OP_W-1:0]      b_shift_in,
  // dynamic controls
  input  wire                 dyn_signed,
  input  wire                 dyn_sub,
  input  wire                 dyn_shift,
  input  wire                 acc_load,
  input  wire [ACC_W-1:0]     acc_init,
  // results
  output reg  [2*OP_W+1:0]    result,
  output reg                  overflow,
  output reg  [OP_W-1:0]      a_shift_out,
  output reg  [OP_W-1:0]      b_shift_out
);

  localparam RW = 2 * OP_W + 2;

  reg  [31:0]      ctrl;
  reg  [31:0]      sel;
  reg  [15:0]      ovf_cnt;
  reg  [3:0]       clk_prev;
  reg  [3:0]       aw_addr;
  reg  [31:0]      w_data;
  reg  [3:0]       w_strb;
  reg  [4*OP_W-1:0] a_q;
  reg  [4*OP_W-1:0] b_q;
  reg  [4*RW-1:0]  p_q;
  reg  [ACC_W-1:0] acc;

  wire [1:0] etype = ctrl[`MDS_F_TYPE_HI:`MDS_F_TYPE_LO];
  wire [1:0] wsel  = ctrl[`MDS_F_WID_HI:`MDS_F_WID_LO];
  wire       dyn   = ctrl[`MDS_F_DYN];
  wire       sgn   = dyn ? dyn_signed : ctrl[`MDS_F_SIGNED];
  wire       sub   = dyn ? dyn_sub    : ctrl[`MDS_F_SUB];
  wire       shl   = dyn ? dyn_shift  : ctrl[`MDS_F_SHIFT];
  wire [3:0] clk_src = {slice_clock_source_3, slice_clock_source_2,
                        slice_clock_source_1, slice_clock_source_0};
  wire [3:0] ce_src  = {slice_enable_source_3, slice_enable_source_2,
                        slice_enable_source_1, slice_enable_source_0};
  wire [3:0] rs_src  = {slice_reset_source_3, slice_reset_source_2,
                        slice_reset_source_1, slice_reset_source_0};

  // elements that fit per width; zero marks an illegal pairing
  function [3:0] max_elem;
    input [1:0] t;
    input [1:0] w;
    begin
      max_elem = 4'h0;
      case (t)
        `MDS_T_PLAIN_MULTIPLY_ELEMENT: max_elem = (w == `MDS_W_9)  ? 4'h8 :
                                (w == `MDS_W_18) ? 4'h4 :
                                (w == `MDS_W_36) ? 4'h1 : 4'h0;
        `MDS_T_MAC:  max_elem = (w == `MDS_W_9 || w == `MDS_W_18) ?
                                4'h2 : 4'h0;
        `MDS_T_TWO:  max_elem = (w == `MDS_W_9)  ? 4'h4 :
                                (w == `MDS_W_18) ? 4'h2 : 4'h0;
        default:     max_elem = (w == `MDS_W_9)  ? 4'h2 :
                                (w == `MDS_W_18) ? 4'h1 : 4'h0;
      endcase
    end
  endfunction

  // operand cut to the shared width, extended by the shared sign
  function [RW-1:0] opx;
    input [OP_W-1:0] v;
    input [1:0]      w;
    input            s;
    begin
      case (w)
        `MDS_W_9:  opx = {{(RW-9){s & v[8]}}, v[8:0]};
        `MDS_W_18: opx = {{(RW-18){s & v[17]}}, v[17:0]};
        default:   opx = {{(RW-OP_W){s & v[OP_W-1]}}, v};
      endcase
    end
  endfunction

  function [RW-1:0] mul;
    input [RW-1:0] x;
    input [RW-1:0] y;
    reg   [2*RW-1:0] t;
    begin
      t   = $signed(x) * $signed(y);
      mul = t[RW-1:0];
    end
  endfunction

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  st;
    integer k;
    begin
      merge = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (st[k]) begin
          merge[8*k +: 8] = nw[8*k +: 8];
        end
      end
    end
  endfunction

  wire [3:0] nmax    = max_elem(etype, wsel);
  wire       cfg_err = (nmax == 4'h0);

  // stage tick: rising edge of chosen clock source and enable
  function tick;
    input [1:0] stg_clk;
    input [1:0] stg_ce;
    input [3:0] cs;
    input [3:0] cp;
    input [3:0] ce;
    begin
      tick = cs[stg_clk] & ~cp[stg_clk] & ce[stg_ce];
    end
  endfunction

  wire [1:0] ck_in  = sel[`MDS_SEL_CLK+`MDS_STG_IN   +: 2];
  wire [1:0] ck_pp  = sel[`MDS_SEL_CLK+`MDS_STG_PIPE +: 2];
  wire [1:0] ck_out = sel[`MDS_SEL_CLK+`MDS_STG_OUT  +: 2];
  wire t_in  = tick(ck_in,  sel[`MDS_SEL_CE+`MDS_STG_IN +: 2],
                    clk_src, clk_prev, ce_src) & ~cfg_err;
  wire t_pp  = tick(ck_pp,  sel[`MDS_SEL_CE+`MDS_STG_PIPE +: 2],
                    clk_src, clk_prev, ce_src) & ~cfg_err;
  wire t_out = tick(ck_out, sel[`MDS_SEL_CE+`MDS_STG_OUT +: 2],
                    clk_src, clk_prev, ce_src) & ~cfg_err;
  wire r_in  = rs_src[sel[`MDS_SEL_RS+`MDS_STG_IN   +: 2]];
  wire r_pp  = rs_src[sel[`MDS_SEL_RS+`MDS_STG_PIPE +: 2]];
  wire r_out = rs_src[sel[`MDS_SEL_RS+`MDS_STG_OUT  +: 2]];

  // input stage source: parallel bus or the previous lane's register
  wire [4*OP_W-1:0] next_a_q = shl ? {a_q[3*OP_W-1:0], a_shift_in} : a_in;
  wire [4*OP_W-1:0] next_b_q = shl ? {b_q[3*OP_W-1:0], b_shift_in} : b_in;
  wire [4*OP_W-1:0] a_op = ctrl[`MDS_F_IN_EN] ? a_q : a_in;
  wire [4*OP_W-1:0] b_op = ctrl[`MDS_F_IN_EN] ? b_q : b_in;

  reg  [4*RW-1:0] prod;
  integer i;
  always @* begin
    prod = {(4*RW){1'b0}};
    for (i = 0; i < 4; i = i + 1) begin
      prod[i*RW +: RW] = mul(opx(a_op[i*OP_W +: OP_W], wsel, sgn),
                             opx(b_op[i*OP_W +: OP_W], wsel, sgn));
    end
  end

  wire [4*RW-1:0] pp = ctrl[`MDS_F_PIPE_EN] ? p_q : prod;
  wire [RW-1:0]   q0 = pp[0 +: RW];
  wire [RW-1:0]   q1 = pp[RW +: RW];
  wire [RW-1:0]   q2 = pp[2*RW +: RW];
  wire [RW-1:0]   q3 = pp[3*RW +: RW];
  wire [RW-1:0]   s01 = sub ? q0 - q1 : q0 + q1;
  wire [RW-1:0]   s23 = sub ? q2 - q3 : q2 + q3;

  // accumulator step and wrap detection
  wire [ACC_W-1:0] pa       = q0[ACC_W-1:0];
  wire [ACC_W-1:0] next_acc = sub ? acc - pa : acc + pa;
  wire sa = acc[ACC_W-1];
  wire sp = pa[ACC_W-1];
  wire sn = next_acc[ACC_W-1];
  wire ovf_u = sub ? (next_acc > acc) : (next_acc < acc);
  wire ovf_s = sub ? ((sa != sp) && (sn != sa))
                   : ((sa == sp) && (sn != sa));
  wire next_ovf = sgn ? ovf_s : ovf_u;

  reg [RW-1:0] next_result;
  always @* begin
    case (etype)
      `MDS_T_PLAIN_MULTIPLY_ELEMENT: next_result = q0;
      `MDS_T_TWO:  next_result = s01;
      `MDS_T_FOUR: next_result = s01 + s23;
      default: next_result = {{(RW-ACC_W){sgn & next_acc[ACC_W-1]}},
                              next_acc};
    endcase
  end

  // datapath; outside mac mode an unregistered output stage still passes
  // through result each clk so that the port stays a flop
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      clk_prev    <= 4'h0;
      a_q         <= {(4*OP_W){1'b0}};
      b_q         <= {(4*OP_W){1'b0}};
      p_q         <= {(4*RW){1'b0}};
      acc         <= {ACC_W{1'b0}};
      result      <= {RW{1'b0}};
      overflow    <= 1'b0;
      a_shift_out <= {OP_W{1'b0}};
      b_shift_out <= {OP_W{1'b0}};
    end else begin
      clk_prev <= clk_src;
      overflow <= 1'b0;
      if (r_in) begin
        a_q <= {(4*OP_W){1'b0}};
        b_q <= {(4*OP_W){1'b0}};
      end else if (t_in) begin
        a_q <= next_a_q;
        b_q <= next_b_q;
      end
      a_shift_out <= a_q[3*OP_W +: OP_W];
      b_shift_out <= b_q[3*OP_W +: OP_W];
      if (r_pp) begin
        p_q <= {(4*RW){1'b0}};
      end else if (t_pp) begin
        p_q <= prod;
      end
      if (r_out) begin
        acc    <= {ACC_W{1'b0}};
        result <= {RW{1'b0}};
      end else if (etype == `MDS_T_MAC) begin
        if (t_out && acc_load) begin
          acc    <= acc_init;
          result <= {{(RW-ACC_W){sgn & acc_init[ACC_W-1]}}, acc_init};
        end else if (t_out) begin
          acc      <= next_acc;
          result   <= next_result;
          overflow <= next_ovf;
        end
      end else if (t_out || (!ctrl[`MDS_F_OUT_EN] && !cfg_err)) begin
        result <= next_result;
      end
    end
  end

  // pulse counter so software can see the wraps
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ovf_cnt <= 16'h0000;
    end else if (overflow) begin
      ovf_cnt <= ovf_cnt + 16'h0001;
    end
  end

  // axi4-lite write path: address and data taken in either order
  wire wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `MDS_RESP_OK;
      aw_addr       <= 4'h0;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      ctrl          <= `MDS_CTRL_RST;
      sel           <= `MDS_SEL_RST;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `MDS_RESP_OK;
        case (aw_addr)
          `MDS_CTRL_OFS:
            ctrl <= merge(ctrl, w_data, w_strb) & `MDS_CTRL_MASK;
          `MDS_SEL_OFS:
            sel <= merge(sel, w_data, w_strb) & `MDS_SEL_MASK;
          `MDS_STAT_OFS: s_axi_bresp <= `MDS_RESP_OK;
          default: s_axi_bresp <= `MDS_RESP_ERR;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // axi4-lite read path
  reg [31:0] rd_val;
  always @* begin
    rd_val = 32'h0000_0000;
    case (s_axi_araddr)
      `MDS_CTRL_OFS: rd_val = ctrl;
      `MDS_SEL_OFS:  rd_val = sel;
      `MDS_STAT_OFS: begin
        rd_val[`MDS_ST_ERR] = cfg_err;
        rd_val[`MDS_ST_MAX_HI:`MDS_ST_MAX_LO] = nmax;
        rd_val[`MDS_ST_CNT_HI:`MDS_ST_CNT_LO] = ovf_cnt;
      end
      default: rd_val = 32'h0000_0000;
    endcase
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `MDS_RESP_OK;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_val;
        case (s_axi_araddr)
          `MDS_CTRL_OFS, `MDS_SEL_OFS, `MDS_STAT_OFS:
            s_axi_rresp <= `MDS_RESP_OK;
          default: s_axi_rresp <= `MDS_RESP_ERR;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// >>> tb/mds_slice_props.sv
/*
  checker for the slice: bus handshake timing and overflow pulse width.
  assumes it is bound onto mds_slice, one clk domain, rstn active low.
*/
`timescale 1ns/1ps
`default_nettype none
module mds_slice_props (
  // system
  input wire logic        clk,
  input wire logic        rstn,
  // register bus handshakes
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // accumulator flag
  input wire logic        overflow
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  chk_ovf_pulse: assert property (overflow |=> !overflow)
    else $error("overflow longer than one cycle");
  chk_b_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
    else $error("write answer late");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid) else $error("write answer dropped");
  chk_b_done: assert property (s_axi_bvalid && s_axi_bready |=>
    !s_axi_bvalid && s_axi_awready && s_axi_wready)
    else $error("write answer not closed");
  chk_b_busy: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready) else $error("write taken while busy");
  chk_r_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && !s_axi_arready) else $error("read answer late");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
  chk_r_done: assert property (s_axi_rvalid && s_axi_rready |=>
    !s_axi_rvalid && s_axi_arready) else $error("read answer not closed");
endmodule

bind mds_slice mds_slice_props mds_slice_props_i (
  .clk, .rstn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .overflow
);
`default_nettype wire

// >>> tb/mds_fabric.sv
/*
  fabric-side partner: counts overflow pulses to widen the accumulator.
  assumes overflow is synchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none
module mds_fabric (
  // system
  input  wire logic        clk,
  input  wire logic        rstn,
  // slice flag
  input  wire logic        overflow,
  // upper accumulator bits
  output var  logic [15:0] ovf_count
);
  // pulses are one cycle wide, so a plain counter needs no edge detect
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) ovf_count <= 16'h0000;
    else if (overflow) ovf_count <= ovf_count + 16'h0001;
  end
endmodule
`default_nettype wire

// >>> tb/mds_slice_tb.sv
/*
  bench for the slice: registers, element types, dynamic controls,
  accumulator wrap and stage source choice.
  assumes the fabric counter beside the slice and a 40 MHz clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mds_map.vh"
`define MDS_CK(g, e) begin check_count++; if ((g) !== (e)) begin \
  miscompares++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module mds_slice_tb;
  logic         clk, rstn, dyn_signed, dyn_sub, dyn_shift, acc_load;
  logic [3:0]   s_axi_awaddr, s_axi_araddr, cs, ce, rs;
  logic [31:0]  s_axi_wdata, s_axi_rdata;
  logic [1:0]   s_axi_bresp, s_axi_rresp;
  logic         s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic         s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic         s_axi_rvalid, s_axi_rready, overflow;
  logic [143:0] a_in, b_in;
  logic [35:0]  a_shift_in, b_shift_in, a_shift_out, b_shift_out;
  logic [51:0]  acc_init;
  logic [73:0]  result;
  logic [15:0]  ovf_count;
  int           miscompares = 0, check_count = 0, cyc = 0, nov;

  mds_slice #(.OP_W(36), .ACC_W(52)) mds_slice_i (
    .clk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready,
    .slice_clock_source_0(cs[0]), .slice_clock_source_1(cs[1]),
    .slice_clock_source_2(cs[2]), .slice_clock_source_3(cs[3]),
    .slice_enable_source_0(ce[0]), .slice_enable_source_1(ce[1]),
    .slice_enable_source_2(ce[2]), .slice_enable_source_3(ce[3]),
    .slice_reset_source_0(rs[0]), .slice_reset_source_1(rs[1]),
    .slice_reset_source_2(rs[2]), .slice_reset_source_3(rs[3]),
    .a_in, .b_in, .a_shift_in, .b_shift_in, .dyn_signed, .dyn_sub,
    .dyn_shift, .acc_load, .acc_init, .result, .overflow, .a_shift_out,
    .b_shift_out
  );
  mds_fabric mds_fabric_i (.clk, .rstn, .overflow, .ovf_count);

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic wrap_up;
    if (miscompares == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // run is a few hundred cycles; the 20000-cycle limit stands well above it
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      wrap_up;
    end
  end

  task automatic axw(input logic [3:0] a, input logic [31:0] d,
                     input logic [1:0] er = `MDS_RESP_OK);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    `MDS_CK(s_axi_bresp, er)
  endtask

  task automatic axr(input logic [3:0] a, input logic [31:0] e,
                     input logic [31:0] m = 32'hFFFF_FFFF,
                     input logic [1:0] er = `MDS_RESP_OK);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    `MDS_CK(s_axi_rdata & m, e)
    `MDS_CK(s_axi_rresp, er)
  endtask

  // one rising sample on a clock source, then count overflow pulses
  task automatic tk(input int s);
    @(posedge clk);
    cs[s] <= 1'b1;
    @(posedge clk);
    cs[s] <= 1'b0;
    nov = 0;
    repeat (6) begin
      @(posedge clk);
      nov += (overflow === 1'b1);
    end
  endtask

  task automatic t_regs;
    axr(`MDS_CTRL_OFS, `MDS_CTRL_RST);
    axr(`MDS_SEL_OFS, `MDS_SEL_RST);
    axw(`MDS_CTRL_OFS, 32'hFFFF_FFFF);
    axr(`MDS_CTRL_OFS, `MDS_CTRL_MASK);
    axw(4'hC, 32'h1234_5678, `MDS_RESP_ERR);
    axr(4'hC, 32'h0000_0000, 32'hFFFF_FFFF, `MDS_RESP_ERR);
  endtask

  task automatic t_limits;
    logic [3:0] mx [12] = '{4'h8, 4'h4, 4'h1, 4'h2, 4'h2, 4'h0,
                            4'h4, 4'h2, 4'h0, 4'h2, 4'h1, 4'h0};
    for (int t = 0; t < 4; t++) begin
      for (int w = 0; w < 4; w++) begin
        axw(`MDS_CTRL_OFS, 32'(t + 4 * w));
        if (w < 3) axr(`MDS_STAT_OFS, {27'h0, mx[t*3+w], mx[t*3+w] == 0},
                       32'h0000_001F);
        else axr(`MDS_STAT_OFS, 32'h0000_0001, 32'h0000_0001);
      end
    end
  endtask

  task automatic t_plain_multiply_element;
    axw(`MDS_CTRL_OFS, 32'h0000_0008);
    @(posedge clk);
    a_in[35:0] <= 36'h8_0000_0003;
    b_in[35:0] <= 36'h0_0000_0005;
    repeat (3) @(posedge clk);
    `MDS_CK(result, 74'h28_0000_000F)
  endtask

  task automatic t_dyn;
    axw(`MDS_CTRL_OFS, 32'h0000_0084);
    @(posedge clk);
    a_in[35:0] <= 36'hF_FFFF_FFFD;
    dyn_signed <= 1'b1;
    repeat (3) @(posedge clk);
    `MDS_CK(result, -74'sd15)
    dyn_signed <= 1'b0;
    repeat (3) @(posedge clk);
    `MDS_CK(result, 74'h13_FFF1)
  endtask

  task automatic t_sums;
    axw(`MDS_CTRL_OFS, 32'h0000_0006);
    a_in <= {36'h6, 36'h4, 36'h9, 36'h64};
    b_in <= {36'h2, 36'h5, 36'hB, 36'h7};
    repeat (3) @(posedge clk);
    `MDS_CK(result, 74'h31F)
    axw(`MDS_CTRL_OFS, 32'h0000_0206);
    repeat (3) @(posedge clk);
    `MDS_CK(result, 74'h259)
    axw(`MDS_CTRL_OFS, 32'h0000_0003);
    repeat (3) @(posedge clk);
    `MDS_CK(result, 74'h33F)
  endtask

  // unsigned wrap near the top of the 52-bit accumulator, both ways
  task automatic t_mac;
    axw(`MDS_CTRL_OFS, 32'h0000_0085);
    acc_init <= 52'hF_FFFF_FFFF_FFF6;
    acc_load <= 1'b1;
    a_in <= {108'h0, 36'h3};
    b_in <= {108'h0, 36'h5};
    tk(0);
    `MDS_CK(result, 74'hF_FFFF_FFFF_FFF6)
    acc_load <= 1'b0;
    tk(0);
    `MDS_CK(result, 74'h5)
    `MDS_CK(nov, 1)
    dyn_sub <= 1'b1;
    tk(0);
    `MDS_CK(result, 74'hF_FFFF_FFFF_FFF6)
    `MDS_CK(nov, 1)
    dyn_sub <= 1'b0;
    `MDS_CK(ovf_count, 16'h0002)
    axr(`MDS_STAT_OFS, 32'h0002_0000, 32'hFFFF_0000);
  endtask

  task automatic t_src;
    axw(`MDS_SEL_OFS, 32'h0000_0010);
    tk(0);
    `MDS_CK(result, 74'hF_FFFF_FFFF_FFF6)
    tk(1);
    `MDS_CK(result, 74'h5)
    axw(`MDS_SEL_OFS, 32'h0000_0C10);
    ce <= 4'h7;
    tk(1);
    `MDS_CK(result, 74'h5)
    axw(`MDS_SEL_OFS, 32'h0002_0010);
    ce <= 4'hF;
    rs <= 4'h4;
    tk(1);
    `MDS_CK(result, 74'h0)
    rs <= 4'h0;
  endtask

  task automatic t_shift;
    axw(`MDS_SEL_OFS, 32'h0000_0000);
    axw(`MDS_CTRL_OFS, 32'h0000_0098);
    dyn_shift <= 1'b1;
    for (int k = 1; k < 5; k++) begin
      a_shift_in <= 36'(k);
      b_shift_in <= 36'(k + 8);
      tk(0);
    end
    `MDS_CK(a_shift_out, 36'h1)
    `MDS_CK(b_shift_out, 36'h9)
    dyn_shift <= 1'b0;
    a_in[143:108] <= 36'h7;
    tk(0);
    `MDS_CK(a_shift_out, 36'h7)
  endtask

  // all three stages on: a product needs three ticks to reach result
  task automatic t_pipe;
    axw(`MDS_CTRL_OFS, `MDS_CTRL_RST);
    a_in[35:0] <= 36'h6;
    b_in[35:0] <= 36'h7;
    tk(0);
    tk(0);
    `MDS_CK(result, 74'hF)
    tk(0);
    `MDS_CK(result, 74'h2A)
  endtask

  // signed wrap: two positives giving a negative sum
  task automatic t_sgn;
    axw(`MDS_CTRL_OFS, 32'h0000_0085);
    dyn_signed <= 1'b1;
    acc_init <= 52'h7_FFFF_FFFF_FFF6;
    acc_load <= 1'b1;
    a_in <= {108'h0, 36'h3};
    b_in <= {108'h0, 36'h5};
    tk(0);
    `MDS_CK(result, 74'h7_FFFF_FFFF_FFF6)
    acc_load <= 1'b0;
    tk(0);
    `MDS_CK(result, 74'h3FF_FFF8_0000_0000_0005)
    `MDS_CK(nov, 1)
    dyn_signed <= 1'b0;
  endtask

  initial begin
    {rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, dyn_signed, dyn_sub} = '0;
    {dyn_shift, acc_load, s_axi_awaddr, s_axi_araddr, cs, rs} = '0;
    {s_axi_wdata, a_in, b_in, a_shift_in, b_shift_in, acc_init} = '0;
    ce = 4'hF;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    t_regs;
    t_limits;
    t_plain_multiply_element;
    t_dyn;
    t_sums;
    t_mac;
    t_src;
    t_shift;
    t_pipe;
    t_sgn;
    wrap_up;
  end
endmodule
`default_nettype wire
